/* logic/sysctl_pkg.sv */
// Package: register map, reset values and field layout of the system control bank
package sysctl_pkg;
  localparam int unsigned ADDR_W = 32;
  localparam int unsigned N_EXT_IRQ = 4;
  localparam logic [31:0] MEMORY_MAP_SELECT_ADDR = 32'he01f_c040;
  localparam logic [31:0] PLL_CONTROL_ADDR = 32'he01f_c080;
  localparam logic [31:0] PLL_CONFIGURATION_ADDR = 32'he01f_c084;
  localparam logic [31:0] PLL_STATE_ADDR = 32'he01f_c088;
  localparam logic [31:0] PLL_COMMIT_SEQUENCE_ADDR = 32'he01f_c08c;
  localparam logic [31:0] POWER_MODE_CONTROL_ADDR = 32'he01f_c0c0;
  localparam logic [31:0] PERIPHERAL_POWER_GATE_ADDR = 32'he01f_c0c4;
  localparam logic [31:0] PERIPHERAL_BUS_DIVIDER_ADDR = 32'he01f_c100;
  localparam logic [31:0] EXT_IRQ_FLAGS_ADDR = 32'he01f_c140;
  localparam logic [31:0] EXT_IRQ_WAKE_ENABLE_ADDR = 32'he01f_c144;
  localparam logic [31:0] EXT_IRQ_LEVEL_OR_EDGE_ADDR = 32'he01f_c148;
  localparam logic [31:0] EXT_IRQ_SENSE_POLARITY_ADDR = 32'he01f_c14c;
  localparam logic [31:0] MISC_SYSTEM_CONTROL_ADDR = 32'he01f_c1a0;
  // Interrupt glue registers placed in a free hole of the map
  localparam logic [31:0] IRQ_STATUS_ADDR = 32'he01f_c150;
  localparam logic [31:0] IRQ_ENABLE_ADDR = 32'he01f_c154;
  localparam logic [31:0] IRQ_CLEAR_ADDR = 32'he01f_c158;
  // Implemented widths of the general registers
  localparam int unsigned PPG_W = 13;
  localparam logic [12:0] PERIPHERAL_POWER_GATE_RST = 13'h1fbe;
  localparam logic [31:0] WORD_ZERO = 32'h0000_0000;
  localparam logic [3:0] NIBBLE_ZERO = 4'h0;
  localparam int unsigned ISP_STRAP_BIT = 1;
  // Status bit layout: flags of the four inputs, then wakeup, then strap
  localparam int unsigned ST_WAKE_BIT = 4;
  localparam int unsigned ST_ISP_BIT = 5;
  localparam int unsigned ST_W = 6;
endpackage : sysctl_pkg

/* logic/system_control_regs_ext_irq.sv */
// System control register bank with four external interrupt inputs
//
// Strobed register access is this design's own decision.
`timescale 1ns/1ns
`default_nettype none
// Overview of operation
// - Each external input selects low level, high level, falling or rising edge
// - Enabled input events raise a wakeup request out of idle or power-down
// - Low on alternate input 1 pin just after reset requests programming handler
// - Low reset input resets the whole bank; processor restarts at address zero
// - Every register sits on its own word-aligned address
// - Reset values cover implemented bits; reserved bits read zero here
// - Peripheral power gate is read/write and resets to 0x1FBE
// - Interrupt flag register reads back flags, a written one clears a flag, and it resets to zero
// - Wakeup, mode and polarity registers are read/write and reset to zero
module system_control_regs_ext_irq
  import sysctl_pkg::*;
#(
  parameter int unsigned N_IRQ = N_EXT_IRQ
) (
  // Clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // Register port
  input wire logic [ADDR_W-1:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [31:0] rdata,
  // External interrupt pins and strap
  input wire logic [N_IRQ-1:0] ext_irq_in,
  input wire logic isp_alt_pin,
  // Requests towards the core
  output logic [N_IRQ-1:0] ext_irq_req,
  output logic wakeup_req,
  output logic isp_request,
  output logic irq,
  // Control values for the rest of the chip
  output logic [31:0] memory_map_select,
  output logic [31:0] pll_control,
  output logic [31:0] pll_configuration,
  output logic [31:0] power_mode_control,
  output logic [PPG_W-1:0] peripheral_power_gate,
  output logic [31:0] peripheral_bus_divider,
  output logic [31:0] misc_system_control,
  output logic pll_commit_pulse
);

  // Register state
  logic [N_IRQ-1:0] flags_r;
  logic [N_IRQ-1:0] flags_nxt;
  logic [N_IRQ-1:0] wake_en_r;
  logic [N_IRQ-1:0] mode_r;
  logic [N_IRQ-1:0] polar_r;
  logic [N_IRQ-1:0] prev_r;
  logic [31:0] mmap_r;
  logic [31:0] pllc_r;
  logic [31:0] pllg_r;
  logic [31:0] power_mode_control_r;
  logic [31:0] div_r;
  logic [31:0] scs_r;
  logic [PPG_W-1:0] ppg_r;
  logic [ST_W-1:0] st_r;
  logic [ST_W-1:0] st_nxt;
  logic [ST_W-1:0] en_r;
  logic [31:0] rdata_r;
  logic isp_r;
  logic strap_done_r;
  logic feed_r;

  // Decoded strobes and derived terms
  logic [N_IRQ-1:0] hit;
  logic [N_IRQ-1:0] clr_flags;
  logic [ST_W-1:0] clr_status;
  logic [ST_W-1:0] ev;
  logic [31:0] rd_mux;
  logic wake;
  logic strap_hit;
  logic wr_mmap;
  logic wr_pllc;
  logic wr_pllg;
  logic wr_feed;
  logic wr_power_mode_control;
  logic wr_ppg;
  logic wr_div;
  logic wr_flags;
  logic wr_wake;
  logic wr_mode;
  logic wr_polar;
  logic wr_scs;
  logic wr_en;
  logic wr_clr;

  function automatic logic hitw(input logic [31:0] a, input logic [31:0] r);
    return wr && (a == r);
  endfunction : hitw

  // Pad a narrow field into a read word; reserved bits read zero
  function automatic logic [31:0] pad_irq(input logic [N_IRQ-1:0] v);
    return {{(32-N_IRQ){1'b0}}, v};
  endfunction : pad_irq

  // One strobe per writable register; only the exact word address matches
  assign wr_mmap = hitw(addr, MEMORY_MAP_SELECT_ADDR);
  assign wr_pllc = hitw(addr, PLL_CONTROL_ADDR);
  assign wr_pllg = hitw(addr, PLL_CONFIGURATION_ADDR);
  assign wr_feed = hitw(addr, PLL_COMMIT_SEQUENCE_ADDR);
  assign wr_power_mode_control = hitw(addr, POWER_MODE_CONTROL_ADDR);
  assign wr_ppg = hitw(addr, PERIPHERAL_POWER_GATE_ADDR);
  assign wr_div = hitw(addr, PERIPHERAL_BUS_DIVIDER_ADDR);
  assign wr_flags = hitw(addr, EXT_IRQ_FLAGS_ADDR);
  assign wr_wake = hitw(addr, EXT_IRQ_WAKE_ENABLE_ADDR);
  assign wr_mode = hitw(addr, EXT_IRQ_LEVEL_OR_EDGE_ADDR);
  assign wr_polar = hitw(addr, EXT_IRQ_SENSE_POLARITY_ADDR);
  assign wr_scs = hitw(addr, MISC_SYSTEM_CONTROL_ADDR);
  assign wr_en = hitw(addr, IRQ_ENABLE_ADDR);
  assign wr_clr = hitw(addr, IRQ_CLEAR_ADDR);
  // Status and enable are our own glue registers outside the documented map

  // Level: mode 0, polarity picks high/low; edge: mode 1, polarity picks rise
  genvar g;
  generate
    for (g = 0; g < N_IRQ; g++) begin : g_sense
      assign hit[g] = mode_r[g] ?
        (polar_r[g] ? (ext_irq_in[g] & ~prev_r[g])
                    : (~ext_irq_in[g] & prev_r[g]))
        : (polar_r[g] ? ext_irq_in[g] : ~ext_irq_in[g]);
    end
  endgenerate

  // Writing a one clears a flag; a new hit in the same cycle still wins
  assign clr_flags = wr_flags ? wdata[N_IRQ-1:0] : '0;
  assign flags_nxt = (flags_r & ~clr_flags) | hit;
  assign wake = |(hit & wake_en_r);
  // Strap is judged from the pin on the single capture edge only
  assign strap_hit = ~strap_done_r & ~isp_alt_pin;
  assign ev = {strap_hit, wake, hit};
  assign clr_status = wr_clr ? wdata[ST_W-1:0] : '0;
  assign st_nxt = (st_r & ~clr_status) | ev;

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      flags_r <= '0;
    end else begin
      flags_r <= flags_nxt;
    end
  end

  // History starts high so a pin held high at release is no rising edge
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      prev_r <= '1;
    end else begin
      prev_r <= ext_irq_in;
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      wake_en_r <= '0;
    end else if (wr_wake) begin
      wake_en_r <= wdata[N_IRQ-1:0];
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      mode_r <= '0;
    end else if (wr_mode) begin
      mode_r <= wdata[N_IRQ-1:0];
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      polar_r <= '0;
    end else if (wr_polar) begin
      polar_r <= wdata[N_IRQ-1:0];
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      mmap_r <= WORD_ZERO;
    end else if (wr_mmap) begin
      mmap_r <= wdata;
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      pllc_r <= WORD_ZERO;
    end else if (wr_pllc) begin
      pllc_r <= wdata;
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      pllg_r <= WORD_ZERO;
    end else if (wr_pllg) begin
      pllg_r <= wdata;
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      power_mode_control_r <= WORD_ZERO;
    end else if (wr_power_mode_control) begin
      power_mode_control_r <= wdata;
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      div_r <= WORD_ZERO;
    end else if (wr_div) begin
      div_r <= wdata;
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      scs_r <= WORD_ZERO;
    end else if (wr_scs) begin
      scs_r <= wdata;
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      ppg_r <= PERIPHERAL_POWER_GATE_RST;
    end else if (wr_ppg) begin
      ppg_r <= wdata[PPG_W-1:0];
    end
  end

  // Strap caught on the first clock after reset release, then frozen
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      isp_r <= 1'b0;
      strap_done_r <= 1'b0;
    end else if (!strap_done_r) begin
      isp_r <= ~isp_alt_pin;
      strap_done_r <= 1'b1;
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      en_r <= '0;
    end else if (wr_en) begin
      en_r <= wdata[ST_W-1:0];
    end
  end

  // Commit write becomes a one-cycle pulse; the register itself reads zero
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      feed_r <= 1'b0;
    end else begin
      feed_r <= wr_feed;
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      rdata_r <= WORD_ZERO;
    end else begin
      rdata_r <= rd ? rd_mux : WORD_ZERO;
    end
  end

  // Word-aligned decode; reserved and unmapped reads return zero
  always_comb begin
    rd_mux = WORD_ZERO;
    unique case (addr)
      MEMORY_MAP_SELECT_ADDR: rd_mux = mmap_r;
      PLL_CONTROL_ADDR: rd_mux = pllc_r;
      PLL_CONFIGURATION_ADDR: rd_mux = pllg_r;
      PLL_STATE_ADDR: rd_mux = WORD_ZERO;
      POWER_MODE_CONTROL_ADDR: rd_mux = power_mode_control_r;
      PERIPHERAL_POWER_GATE_ADDR: rd_mux = {{(32-PPG_W){1'b0}}, ppg_r};
      PERIPHERAL_BUS_DIVIDER_ADDR: rd_mux = div_r;
      EXT_IRQ_FLAGS_ADDR: rd_mux = pad_irq(flags_r);
      EXT_IRQ_WAKE_ENABLE_ADDR: rd_mux = pad_irq(wake_en_r);
      EXT_IRQ_LEVEL_OR_EDGE_ADDR: rd_mux = pad_irq(mode_r);
      EXT_IRQ_SENSE_POLARITY_ADDR: rd_mux = pad_irq(polar_r);
      MISC_SYSTEM_CONTROL_ADDR: rd_mux = scs_r;
      IRQ_STATUS_ADDR: rd_mux = {{(32-ST_W){1'b0}}, st_r};
      IRQ_ENABLE_ADDR: rd_mux = {{(32-ST_W){1'b0}}, en_r};
      default: rd_mux = WORD_ZERO;
    endcase
  end

  assign rdata = rdata_r;
  assign ext_irq_req = flags_r;
  assign wakeup_req = |(flags_r & wake_en_r);
  assign isp_request = isp_r;
  assign irq = |(st_r & en_r);
  assign memory_map_select = mmap_r;
  assign pll_control = pllc_r;
  assign pll_configuration = pllg_r;
  assign power_mode_control = power_mode_control_r;
  assign peripheral_power_gate = ppg_r;
  assign peripheral_bus_divider = div_r;
  assign misc_system_control = scs_r;
  assign pll_commit_pulse = feed_r;

  // Assertions
  flag_sets_a: assert property (
    @(posedge clock) disable iff (!rst_n) hit[0] |=> flags_r[0])
    else $error("flag 0 not set on hit");
  flag_holds_a: assert property (
    @(posedge clock) disable iff (!rst_n)
    flags_r[1] && !clr_flags[1] |=> flags_r[1])
    else $error("flag 1 lost without clear");
  flag_clear_a: assert property (
    @(posedge clock) disable iff (!rst_n)
    wr_flags && wdata[0] && !hit[0] |=> !flags_r[0])
    else $error("flag 0 not cleared by write");
  level_low_a: assert property (
    @(posedge clock) disable iff (!rst_n)
    !mode_r[2] && !polar_r[2] && !ext_irq_in[2] |=> flags_r[2])
    else $error("low level not flagged");
  level_high_a: assert property (
    @(posedge clock) disable iff (!rst_n)
    !mode_r[1] && polar_r[1] && ext_irq_in[1] |-> hit[1])
    else $error("high level missed");
  rise_edge_a: assert property (
    @(posedge clock) disable iff (!rst_n)
    mode_r[3] && polar_r[3] && $rose(ext_irq_in[3]) |-> hit[3])
    else $error("rising edge missed");
  fall_edge_a: assert property (
    @(posedge clock) disable iff (!rst_n)
    mode_r[0] && !polar_r[0] && $fell(ext_irq_in[0]) |-> hit[0])
    else $error("falling edge missed");
  wake_req_a: assert property (
    @(posedge clock) disable iff (!rst_n)
    (|(hit & wake_en_r)) |=> wakeup_req)
    else $error("wakeup not raised");
  wake_gate_a: assert property (
    @(posedge clock) disable iff (!rst_n) wakeup_req |-> (|wake_en_r))
    else $error("wakeup without enable");
  ppg_reset_a: assert property (
    @(posedge clock)
    !rst_n |=> peripheral_power_gate == PERIPHERAL_POWER_GATE_RST)
    else $error("power gate reset wrong");
  ppg_write_a: assert property (
    @(posedge clock) disable iff (!rst_n)
    wr_ppg |=> ppg_r == $past(wdata[PPG_W-1:0]))
    else $error("power gate write lost");
  flags_reset_a: assert property (
    @(posedge clock)
    !rst_n |=> flags_r == '0 && wake_en_r == '0 && mode_r == '0)
    else $error("ext registers not zero after reset");
  polar_reset_a: assert property (
    @(posedge clock) !rst_n |=> polar_r == '0 && st_r == '0)
    else $error("polarity or status not zero after reset");
  mode_write_a: assert property (
    @(posedge clock) disable iff (!rst_n)
    wr_mode |=> mode_r == $past(wdata[N_IRQ-1:0]))
    else $error("mode write lost");
  rd_flags_a: assert property (
    @(posedge clock) disable iff (!rst_n)
    rd && addr == EXT_IRQ_FLAGS_ADDR |=> rdata == pad_irq($past(flags_r)))
    else $error("flag readback wrong");
  rdata_idle_a: assert property (
    @(posedge clock) disable iff (!rst_n) !rd |=> rdata == WORD_ZERO)
    else $error("read data not zero outside read");
  isp_strap_a: assert property (
    @(posedge clock) disable iff (!rst_n) strap_done_r |=> $stable(isp_r))
    else $error("strap changed after capture");
  strap_take_a: assert property (
    @(posedge clock) disable iff (!rst_n)
    !strap_done_r && !isp_alt_pin |=> isp_request)
    else $error("strap low not captured");
  strap_once_a: assert property (
    @(posedge clock) disable iff (!rst_n)
    strap_done_r |-> !ev[ST_ISP_BIT])
    else $error("strap event repeated");
  wake_status_a: assert property (
    @(posedge clock) disable iff (!rst_n)
    ev[ST_WAKE_BIT] |=> st_r[ST_WAKE_BIT])
    else $error("wakeup status not set");
  feed_pulse_a: assert property (
    @(posedge clock) disable iff (!rst_n) wr_feed |=> pll_commit_pulse)
    else $error("commit pulse missing");

  // Main scenarios
  c_edge_c: cover property (@(posedge clock) mode_r[0] && hit[0]);
  c_wake_c: cover property (@(posedge clock) wakeup_req);
  c_irq_c: cover property (@(posedge clock) irq);
  c_isp_c: cover property (@(posedge clock) isp_request);
  c_clear_c: cover property (@(posedge clock) wr_flags && (|hit));

endmodule : system_control_regs_ext_irq
`default_nettype wire

/* verification/ext_src_model.sv */
// Model of the external interrupt sources and the board strap line
`timescale 1ns/1ns
`default_nettype none
module ext_src_model (
  // Pins towards the bank
  output logic [3:0] pins,
  output logic strap_n
);
  // Interrupt lines idle high, as pulled up on the board; strap line starts low
  initial begin
    pins = 4'hf;
    strap_n = 1'b0;
  end
  // Called just after a rising edge, so pins change off the sampling edge
  task automatic drive(input logic [3:0] p, input logic s);
    pins <= p;
    strap_n <= s;
  endtask : drive
endmodule : ext_src_model
`default_nettype wire

/* verification/tb_top.sv */
// Register-level testbench of the system control bank
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  import sysctl_pkg::*;
  logic clock = 1'b0;
  logic rst_n = 1'b0;
  logic [31:0] addr = '0;
  logic [31:0] wdata = '0;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [31:0] rdata, got;
  logic [3:0] pins, req;
  logic strap_n, wake, in_system_programming, irq;
  logic [12:0] ppg;
  int bad_count = 0;
  int n_checks = 0;
  int cycles = 0;
  always #2 clock = ~clock;
  ext_src_model src (.pins(pins), .strap_n(strap_n));
  system_control_regs_ext_irq dut (.clock(clock), .rst_n(rst_n),
    .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
    .ext_irq_in(pins), .isp_alt_pin(strap_n), .ext_irq_req(req),
    .wakeup_req(wake), .isp_request(in_system_programming), .irq(irq),
    .memory_map_select(), .pll_control(), .pll_configuration(),
    .power_mode_control(), .peripheral_power_gate(ppg),
    .peripheral_bus_divider(), .misc_system_control(),
    .pll_commit_pulse());
  task automatic test_done;
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : test_done
  // Hang guard: the whole sequence needs about 80 cycles
  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      bad_count++;
      test_done();
    end
  end
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_checks++;
    if (g !== e) begin
      bad_count++;
      $display("ERROR t=%0t got %h exp %h", $time, g, e);
    end
  endtask : chk
  task automatic wreg(input logic [31:0] a, input logic [31:0] d);
    @(posedge clock);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clock);
    wr <= 1'b0;
  endtask : wreg
  // Read data stand only in the cycle after the strobe
  task automatic rreg(input logic [31:0] a, input logic [31:0] e);
    @(posedge clock);
    addr <= a;
    rd <= 1'b1;
    @(posedge clock);
    rd <= 1'b0;
    #1 got = rdata;
    chk(got, e);
  endtask : rreg
  task automatic step(input logic [3:0] p);
    @(posedge clock);
    src.drive(p, 1'b1);
    repeat (2) @(posedge clock);
  endtask : step
  initial begin
    repeat (10) @(posedge clock);
    rst_n <= 1'b1;
    repeat (3) @(posedge clock);
    chk({31'h0, in_system_programming}, 32'h0000_0001);
    step(4'hf);
    rreg(EXT_IRQ_FLAGS_ADDR, WORD_ZERO);
    rreg(EXT_IRQ_WAKE_ENABLE_ADDR, WORD_ZERO);
    rreg(EXT_IRQ_LEVEL_OR_EDGE_ADDR, WORD_ZERO);
    rreg(EXT_IRQ_SENSE_POLARITY_ADDR, WORD_ZERO);
    rreg(PERIPHERAL_POWER_GATE_ADDR, 32'h0000_1fbe);
    rreg(32'he01f_c200, WORD_ZERO);
    wreg(PERIPHERAL_POWER_GATE_ADDR, 32'hffff_ffff);
    rreg(PERIPHERAL_POWER_GATE_ADDR, 32'h0000_1fff);
    chk({19'h0, ppg}, 32'h0000_1fff);
    $display("test reset and access done");
    wreg(EXT_IRQ_LEVEL_OR_EDGE_ADDR, 32'h0000_0003);
    wreg(EXT_IRQ_SENSE_POLARITY_ADDR, 32'h0000_0002);
    rreg(EXT_IRQ_LEVEL_OR_EDGE_ADDR, 32'h0000_0003);
    step(4'he);
    step(4'hc);
    rreg(EXT_IRQ_FLAGS_ADDR, 32'h0000_0001);
    step(4'he);
    rreg(EXT_IRQ_FLAGS_ADDR, 32'h0000_0003);
    chk({28'h0, req}, 32'h0000_0003);
    chk({31'h0, irq}, WORD_ZERO);
    wreg(EXT_IRQ_FLAGS_ADDR, 32'h0000_0003);
    rreg(EXT_IRQ_FLAGS_ADDR, WORD_ZERO);
    step(4'h6);
    wreg(EXT_IRQ_FLAGS_ADDR, 32'h0000_0008);
    rreg(EXT_IRQ_FLAGS_ADDR, 32'h0000_0008);
    chk({31'h0, wake}, WORD_ZERO);
    wreg(EXT_IRQ_WAKE_ENABLE_ADDR, 32'h0000_0008);
    #1 chk({31'h0, wake}, 32'h0000_0001);
    step(4'hf);
    wreg(EXT_IRQ_FLAGS_ADDR, 32'h0000_0008);
    rreg(EXT_IRQ_FLAGS_ADDR, WORD_ZERO);
    chk({31'h0, wake}, WORD_ZERO);
    $display("test pin sensing done");
    rreg(IRQ_STATUS_ADDR, 32'h0000_003b);
    wreg(IRQ_ENABLE_ADDR, 32'h0000_0001);
    #1 chk({31'h0, irq}, 32'h0000_0001);
    wreg(IRQ_CLEAR_ADDR, 32'h0000_003f);
    #1 chk({31'h0, irq}, WORD_ZERO);
    rreg(IRQ_STATUS_ADDR, WORD_ZERO);
    $display("test interrupt done");
    test_done();
  end
endmodule : tb_top
`default_nettype wire
